/* File: design/crf_core.sv */
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module crf_core (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic SRST_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Sequencer register operations
    input wire crf_pkg::crf_op_e OP_I,
    input wire crf_pkg::crf_pcop_e PC_OP_I,
    input wire crf_pkg::crf_flop_e FL_OP_I,
    input wire logic [15:0] DATA_I,
    input wire logic [7:0] ALU_A_I,
    input wire logic [7:0] ALU_B_I,
    input wire logic ALU_CIN_I,
    input wire logic [7:0] ALU_RES_I,
    input wire logic SHIFT_C_I,
    input wire logic SET_I_I,
    input wire logic CLR_I_I,
    input wire logic IRQ_REQ_I,
    input wire logic BOUNDARY_I,
    input wire logic PAGE_LD_I,
    input wire logic [15:0] CPU_ADDR_I,
    // Register and status outputs
    output logic [7:0] ACC_O,
    output logic [15:0] IDX_O,
    output logic [15:0] STACK_PTR_O,
    output logic [15:0] PC_O,
    output logic [7:0] CCR_O,
    output logic [7:0] PROGRAM_PAGE_O,
    output logic [21:0] PHYS_ADDR_O,
    output logic IRQ_TAKE_O,
    output logic STK_WE_O,
    output logic [15:0] STK_ADDR_O,
    output logic [7:0] STK_DATA_O
);
    import crf_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] acc_r; // Accumulator, no reset
    logic [7:0] idxh_r; // Index high byte
    logic [7:0] idxl_r; // Index low byte, no reset
    logic [15:0] sp_r; // Stack pointer
    logic [15:0] pc_r; // Program counter
    logic [7:0] ccr_r; // Flags; bits 6:5 forced
    logic [7:0] page_r; // Program page
    logic irq_hold_r; // Blocks one boundary after clear
    crf_stk_e stk_r; // Stacking step
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [21:0] phys_r;
    logic stk_we_r;
    logic [15:0] stk_addr_r;
    logic [7:0] stk_data_r;
    logic take_r;

    // APB decoding
    logic apb_wr; // Write access phase
    logic apb_rd; // Setup of a read
    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign apb_rd = PSEL_I && !PENABLE_I && !PWRITE_I;

    ////////////////////////////////////////////////////////////////////
    // Flag computation
    logic [8:0] sum9; // Add with carry out
    logic [8:0] dif9; // Subtract with borrow out
    logic [4:0] half5; // Low nibble add
    logic [7:0] daa_cor; // Decimal correction value
    logic daa_c; // Carry after decimal adjust
    logic [7:0] daa_res; // Adjusted accumulator
    logic [7:0] ccr_nxt; // Next flags from operation
    assign sum9 = {1'b0, ALU_A_I} + {1'b0, ALU_B_I} + {8'h00, ALU_CIN_I};
    assign dif9 = {1'b0, ALU_A_I} - {1'b0, ALU_B_I} - {8'h00, ALU_CIN_I};
    assign half5 = {1'b0, ALU_A_I[3:0]} + {1'b0, ALU_B_I[3:0]} + {4'h0, ALU_CIN_I};

    // Correction table for decimal adjust
    always_comb begin
        daa_cor = 8'h00;
        daa_c = ccr_r[CCR_C];
        if (ccr_r[CCR_H] || (acc_r[3:0] > 4'h9)) begin
            daa_cor[3:0] = 4'h6;
        end
        if (ccr_r[CCR_C] || (acc_r > 8'h99)) begin
            daa_cor[7:4] = 4'h6;
            daa_c = 1'b1;
        end
        daa_res = acc_r + daa_cor;
    end

    // Next flag value per operation
    always_comb begin
        ccr_nxt = ccr_r;
        unique case (FL_OP_I)
            CRF_FL_ADD: begin
                ccr_nxt[CCR_H] = half5[4];
                ccr_nxt[CCR_C] = sum9[8];
                ccr_nxt[CCR_V] = (ALU_A_I[7] == ALU_B_I[7]) && (sum9[7] != ALU_A_I[7]);
                ccr_nxt[CCR_N] = sum9[7];
                ccr_nxt[CCR_Z] = (sum9[7:0] == 8'h00);
            end
            CRF_FL_SUB: begin
                ccr_nxt[CCR_C] = dif9[8];
                ccr_nxt[CCR_V] = (ALU_A_I[7] != ALU_B_I[7]) && (dif9[7] != ALU_A_I[7]);
                ccr_nxt[CCR_N] = dif9[7];
                ccr_nxt[CCR_Z] = (dif9[7:0] == 8'h00);
            end
            CRF_FL_NZ8: begin
                ccr_nxt[CCR_N] = ALU_RES_I[7];
                ccr_nxt[CCR_Z] = (ALU_RES_I == 8'h00);
                ccr_nxt[CCR_V] = 1'b0;
            end
            CRF_FL_NZ16: begin
                ccr_nxt[CCR_N] = DATA_I[15];
                ccr_nxt[CCR_Z] = (DATA_I == 16'h0000);
                ccr_nxt[CCR_V] = 1'b0;
            end
            CRF_FL_SHIFT: begin
                ccr_nxt[CCR_C] = SHIFT_C_I;
                ccr_nxt[CCR_N] = ALU_RES_I[7];
                ccr_nxt[CCR_Z] = (ALU_RES_I == 8'h00);
            end
            CRF_FL_WRITE: ccr_nxt = DATA_I[7:0];
            default: ccr_nxt = ccr_r;
        endcase
        if (OP_I == CRF_OP_DAA) begin
            ccr_nxt[CCR_C] = daa_c;
            ccr_nxt[CCR_N] = daa_res[7];
            ccr_nxt[CCR_Z] = (daa_res == 8'h00);
        end
        ccr_nxt = ccr_nxt | CCR_FIXED;
    end

    ////////////////////////////////////////////////////////////////////
    // Accumulator, never reset
    always_ff @(posedge CLK_SYS_I) begin
        if (OP_I == CRF_OP_LDA) begin
            acc_r <= ALU_RES_I;
        end else if (OP_I == CRF_OP_DAA) begin
            acc_r <= daa_res;
        end else if (apb_wr && PADDR_I == OFF_ACC) begin
            acc_r <= PWDATA_I[7:0];
        end
    end

    // Index low byte, never reset
    always_ff @(posedge CLK_SYS_I) begin
        if (OP_I == CRF_OP_LDX) begin
            idxl_r <= ALU_RES_I;
        end else if (OP_I == CRF_OP_LDHX) begin
            idxl_r <= DATA_I[7:0];
        end else if (OP_I == CRF_OP_INCHX) begin
            idxl_r <= idxl_r + 8'h01;
        end else if (apb_wr && PADDR_I == OFF_IDX) begin
            idxl_r <= PWDATA_I[7:0];
        end
    end

    // Index high byte, cleared by reset
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            idxh_r <= IDXH_RST;
        end else if (OP_I == CRF_OP_LDH) begin
            idxh_r <= ALU_RES_I;
        end else if (OP_I == CRF_OP_LDHX) begin
            idxh_r <= DATA_I[15:8];
        end else if (OP_I == CRF_OP_INCHX && idxl_r == 8'hFF) begin
            idxh_r <= idxh_r + 8'h01;
        end else if (apb_wr && PADDR_I == OFF_IDX) begin
            idxh_r <= PWDATA_I[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stack pointer
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            sp_r <= SP_RST;
        end else if (stk_r != CRF_ST_IDLE || OP_I == CRF_OP_PUSH) begin
            sp_r <= sp_r - 16'h0001;
        end else if (OP_I == CRF_OP_PULL) begin
            sp_r <= sp_r + 16'h0001;
        end else if (OP_I == CRF_OP_LDSP) begin
            sp_r <= DATA_I;
        end else if (OP_I == CRF_OP_AIS) begin
            sp_r <= sp_r + {{8{DATA_I[7]}}, DATA_I[7:0]};
        end else if (OP_I == CRF_OP_RSP) begin
            sp_r[7:0] <= SP_RST[7:0];
        end else if (apb_wr && PADDR_I == OFF_SP) begin
            sp_r <= PWDATA_I[15:0];
        end
    end

    // Program counter
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            pc_r <= VEC_HI_ADDR;
        end else begin
            unique case (PC_OP_I)
                CRF_PC_HOLD: pc_r <= pc_r;
                CRF_PC_INC: pc_r <= pc_r + 16'h0001;
                CRF_PC_LOAD: pc_r <= DATA_I;
                CRF_PC_BRANCH: pc_r <= pc_r + {{8{DATA_I[7]}}, DATA_I[7:0]};
                CRF_PC_VECHI: pc_r[15:8] <= DATA_I[7:0];
                CRF_PC_VECLO: pc_r[7:0] <= DATA_I[7:0];
                default: pc_r <= pc_r;
            endcase
        end
    end

    // Flags and mask
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            ccr_r <= CCR_RST;
        end else if (stk_r == CRF_ST_CCR || SET_I_I) begin
            ccr_r <= ccr_nxt | (8'h01 << CCR_I);
        end else if (CLR_I_I) begin
            ccr_r <= ccr_nxt & ~(8'h01 << CCR_I);
        end else if (apb_wr && PADDR_I == OFF_CCR) begin
            ccr_r <= PWDATA_I[7:0] | CCR_FIXED;
        end else begin
            ccr_r <= ccr_nxt;
        end
    end

    // Program page for far call and return
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            page_r <= 8'h00;
        end else if (PAGE_LD_I) begin
            page_r <= DATA_I[7:0];
        end else if (apb_wr && PADDR_I == OFF_PAGE) begin
            page_r <= PWDATA_I[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt acceptance with one-boundary hold after a clear
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            irq_hold_r <= 1'b0;
            take_r <= 1'b0;
        end else begin
            take_r <= 1'b0;
            if (CLR_I_I && ccr_r[CCR_I]) begin
                irq_hold_r <= 1'b1;
            end else if (BOUNDARY_I) begin
                irq_hold_r <= 1'b0;
                take_r <= IRQ_REQ_I && !ccr_r[CCR_I] && !irq_hold_r
                    && stk_r == CRF_ST_IDLE;
            end
        end
    end

    // Stacking sequencer for interrupt entry
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            stk_r <= CRF_ST_IDLE;
        end else begin
            unique case (stk_r)
                CRF_ST_IDLE: stk_r <= take_r ? CRF_ST_PCL : CRF_ST_IDLE;
                CRF_ST_PCL: stk_r <= CRF_ST_PCH;
                CRF_ST_PCH: stk_r <= CRF_ST_X;
                CRF_ST_X: stk_r <= CRF_ST_A;
                CRF_ST_A: stk_r <= CRF_ST_CCR;
                CRF_ST_CCR: stk_r <= CRF_ST_IDLE;
                default: stk_r <= CRF_ST_IDLE;
            endcase
        end
    end

    // Stack write port
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            stk_we_r <= 1'b0;
            stk_addr_r <= 16'h0000;
            stk_data_r <= 8'h00;
        end else begin
            stk_we_r <= (stk_r != CRF_ST_IDLE);
            stk_addr_r <= sp_r;
            unique case (stk_r)
                CRF_ST_PCL: stk_data_r <= pc_r[7:0];
                CRF_ST_PCH: stk_data_r <= pc_r[15:8];
                CRF_ST_X: stk_data_r <= idxl_r;
                CRF_ST_A: stk_data_r <= acc_r;
                CRF_ST_CCR: stk_data_r <= ccr_r;
                default: stk_data_r <= 8'h00;
            endcase
        end
    end

    // Paged window mapping into physical address
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            phys_r <= 22'h000000;
        end else if (CPU_ADDR_I >= WIN_LO && CPU_ADDR_I <= WIN_HI) begin
            phys_r <= {page_r, CPU_ADDR_I[13:0]};
        end else begin
            phys_r <= {6'h00, CPU_ADDR_I};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB read path, no wait states
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= PSEL_I && !PENABLE_I;
            pslverr_r <= 1'b0;
            if (apb_rd) begin
                unique case (PADDR_I)
                    OFF_ACC: prdata_r <= {24'h000000, acc_r};
                    OFF_IDX: prdata_r <= {16'h0000, idxh_r, idxl_r};
                    OFF_SP: prdata_r <= {16'h0000, sp_r};
                    OFF_PC: prdata_r <= {16'h0000, pc_r};
                    OFF_CCR: prdata_r <= {24'h000000, ccr_r};
                    OFF_PAGE: prdata_r <= {24'h000000, page_r};
                    OFF_STAT: prdata_r <= {29'h0000000, stk_r};
                    default: begin
                        prdata_r <= 32'h00000000;
                        pslverr_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Output connections
    assign ACC_O = acc_r;
    assign IDX_O = {idxh_r, idxl_r};
    assign STACK_PTR_O = sp_r;
    assign PC_O = pc_r;
    assign CCR_O = ccr_r;
    assign PROGRAM_PAGE_O = page_r;
    assign PHYS_ADDR_O = phys_r;
    assign IRQ_TAKE_O = take_r;
    assign STK_WE_O = stk_we_r;
    assign STK_ADDR_O = stk_addr_r;
    assign STK_DATA_O = stk_data_r;
    assign PRDATA_O = prdata_r;
    assign PREADY_O = pready_r;
    assign PSLVERR_O = pslverr_r;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_take;
        take_r;
    endsequence
    sequence s_five_pushes;
        stk_we_r [*5];
    endsequence

    property p_sp_rst;
        @(posedge CLK_SYS_I) $past(SRST_I) |-> sp_r == 16'h00FF;
    endproperty
    a_sp_rst: assert property (p_sp_rst) else $error("stack ptr reset wrong");

    property p_idxh_rst;
        @(posedge CLK_SYS_I) $past(SRST_I) |-> idxh_r == 8'h00;
    endproperty
    a_idxh_rst: assert property (p_idxh_rst) else $error("index high not cleared");

    property p_fixed;
        @(posedge CLK_SYS_I) disable iff (SRST_I) ccr_r[6:5] == 2'b11;
    endproperty
    a_fixed: assert property (p_fixed) else $error("flag bits 6:5 not one");

    property p_pc_inc;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
            PC_OP_I == CRF_PC_INC |=> pc_r == $past(pc_r) + 16'h0001;
    endproperty
    a_pc_inc: assert property (p_pc_inc) else $error("pc did not increment");

    property p_rsp;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
            OP_I == CRF_OP_RSP && stk_r == CRF_ST_IDLE
            |=> sp_r[15:8] == $past(sp_r[15:8]) && sp_r[7:0] == 8'hFF;
    endproperty
    a_rsp: assert property (p_rsp) else $error("stack low reset wrong");

    property p_hold;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
            CLR_I_I && ccr_r[3] ##1 BOUNDARY_I |=> !take_r;
    endproperty
    a_hold: assert property (p_hold) else $error("interrupt taken after clear");

    property p_stack;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
            s_take |-> ##2 s_five_pushes ##0 ccr_r[3];
    endproperty
    a_stack: assert property (p_stack) else $error("stacking sequence wrong");

    property p_window;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
            CPU_ADDR_I[15:14] == 2'b10 |=> phys_r[21:14] == $past(page_r);
    endproperty
    a_window: assert property (p_window) else $error("page window wrong");
endmodule

/* File: design/crf_pkg.sv */
package crf_pkg;
    // Register widths
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    // Reset values
    localparam logic [7:0] IDXH_RST = 8'h00;
    localparam logic [15:0] SP_RST = 16'h00FF;
    // Reset vector addresses
    localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
    localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
    // Flag bit positions
    localparam int CCR_C = 0;
    localparam int CCR_Z = 1;
    localparam int CCR_N = 2;
    localparam int CCR_I = 3;
    localparam int CCR_H = 4;
    localparam int CCR_ONE5 = 5;
    localparam int CCR_ONE6 = 6;
    localparam int CCR_V = 7;
    localparam logic [7:0] CCR_FIXED = 8'h60;
    localparam logic [7:0] CCR_RST = 8'h68;
    // Paged window
    localparam logic [15:0] WIN_LO = 16'h8000;
    localparam logic [15:0] WIN_HI = 16'hBFFF;
    localparam int PAGE_W = 8;
    localparam int PHYS_W = 22;
    // APB offsets (byte addresses)
    localparam logic [7:0] OFF_ACC = 8'h00;
    localparam logic [7:0] OFF_IDX = 8'h04;
    localparam logic [7:0] OFF_SP = 8'h08;
    localparam logic [7:0] OFF_PC = 8'h0C;
    localparam logic [7:0] OFF_CCR = 8'h10;
    localparam logic [7:0] OFF_PAGE = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    // Register operation codes from the sequencer
    typedef enum logic [3:0] {
        CRF_OP_NONE = 4'h0,
        CRF_OP_LDA = 4'h1,
        CRF_OP_LDX = 4'h2,
        CRF_OP_LDH = 4'h3,
        CRF_OP_LDHX = 4'h4,
        CRF_OP_INCHX = 4'h5,
        CRF_OP_LDSP = 4'h6,
        CRF_OP_AIS = 4'h7,
        CRF_OP_RSP = 4'h8,
        CRF_OP_PUSH = 4'h9,
        CRF_OP_PULL = 4'hA,
        CRF_OP_DAA = 4'hB
    } crf_op_e;
    // Program counter operation codes
    typedef enum logic [2:0] {
        CRF_PC_HOLD = 3'h0,
        CRF_PC_INC = 3'h1,
        CRF_PC_LOAD = 3'h2,
        CRF_PC_BRANCH = 3'h3,
        CRF_PC_VECHI = 3'h4,
        CRF_PC_VECLO = 3'h5
    } crf_pcop_e;
    // Flag operation codes
    typedef enum logic [2:0] {
        CRF_FL_NONE = 3'h0,
        CRF_FL_ADD = 3'h1,
        CRF_FL_SUB = 3'h2,
        CRF_FL_NZ8 = 3'h3,
        CRF_FL_NZ16 = 3'h4,
        CRF_FL_SHIFT = 3'h5,
        CRF_FL_WRITE = 3'h6
    } crf_flop_e;
    // Interrupt entry stacking steps
    typedef enum logic [2:0] {
        CRF_ST_IDLE = 3'h0,
        CRF_ST_PCL = 3'h1,
        CRF_ST_PCH = 3'h2,
        CRF_ST_X = 3'h3,
        CRF_ST_A = 3'h4,
        CRF_ST_CCR = 3'h5
    } crf_stk_e;
endpackage

/* File: sim/cpu8_register_file_ccr_tb.sv */
`timescale 1ns/1ns
module cpu8_register_file_ccr_tb;
    import crf_pkg::*;
    // Clock, reset and bus
    logic clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err;
    // Sequencer side
    crf_op_e op;
    crf_pcop_e pc_op;
    crf_flop_e fl_op;
    logic [15:0] data, cpu_addr, idx, sp, pc;
    logic [7:0] alu_a, alu_b, alu_res, acc, ccr, page, stk_data;
    logic alu_cin, shift_c, set_i, clr_i, irq_req, boundary, page_ld;
    logic [21:0] phys;
    logic irq_take, stk_we;
    logic [15:0] stk_addr;
    // Counters
    int fail_count, n_compared;
    ////////////////////////////////////////////////////////////
    crf_core uut (.CLK_SYS_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .OP_I(op), .PC_OP_I(pc_op),
        .FL_OP_I(fl_op), .DATA_I(data), .ALU_A_I(alu_a), .ALU_B_I(alu_b),
        .ALU_CIN_I(alu_cin), .ALU_RES_I(alu_res), .SHIFT_C_I(shift_c), .SET_I_I(set_i),
        .CLR_I_I(clr_i), .IRQ_REQ_I(irq_req), .BOUNDARY_I(boundary), .PAGE_LD_I(page_ld),
        .CPU_ADDR_I(cpu_addr), .ACC_O(acc), .IDX_O(idx), .STACK_PTR_O(sp), .PC_O(pc),
        .CCR_O(ccr), .PROGRAM_PAGE_O(page), .PHYS_ADDR_O(phys), .IRQ_TAKE_O(irq_take),
        .STK_WE_O(stk_we), .STK_ADDR_O(stk_addr), .STK_DATA_O(stk_data));
    // Far-side stack memory
    crf_stack_mem mem (.clk_i(clk), .we_i(stk_we), .addr_i(stk_addr), .data_i(stk_data));
    ////////////////////////////////////////////////////////////
    // Clock of 100 ns
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One sequencer cycle; s = set, clear, page, boundary, shift; al = a, b, cin, result
    task automatic seq(input crf_op_e o, input crf_pcop_e p, input crf_flop_e f,
        input logic [15:0] d, input logic [4:0] s = 5'h0, input logic [24:0] al = 25'h0);
        @(posedge clk);
        op <= o;
        pc_op <= p;
        fl_op <= f;
        data <= d;
        {set_i, clr_i, page_ld, boundary, shift_c} <= s;
        {alu_a, alu_b, alu_cin, alu_res} <= al;
        @(posedge clk);
        op <= CRF_OP_NONE;
        pc_op <= CRF_PC_HOLD;
        fl_op <= CRF_FL_NONE;
        {set_i, clr_i, page_ld, boundary} <= 4'h0;
        @(negedge clk);
    endtask
    // One APB transfer, waiting for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        // Wait for pready at a rising edge; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // Synchronous reset held two cycles
    task automatic do_reset;
        @(posedge clk);
        srst <= 1'h1;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////
    // Reset values and what reset leaves alone
    task automatic t_reset;
        chk("sp", sp, 16'h00FF);
        chk("pc", pc, 16'hFFFE);
        chk("ccr", ccr, 8'h68);
        seq(CRF_OP_LDA, CRF_PC_HOLD, CRF_FL_NONE, 16'h0000, 5'h0, {17'h0, 8'h5A});
        seq(CRF_OP_LDHX, CRF_PC_HOLD, CRF_FL_NONE, 16'h1234);
        chk("idx", idx, 16'h1234);
        do_reset();
        chk("acc", acc, 8'h5A);
        chk("idx", idx, 16'h0034);
        seq(CRF_OP_LDH, CRF_PC_HOLD, CRF_FL_NONE, 16'h0000, 5'h0, {17'h0, 8'h77});
        seq(CRF_OP_LDX, CRF_PC_HOLD, CRF_FL_NONE, 16'h0000, 5'h0, {17'h0, 8'h66});
        chk("idx ld", idx, 16'h7766);
        seq(CRF_OP_LDHX, CRF_PC_HOLD, CRF_FL_NONE, 16'h12FF);
        seq(CRF_OP_INCHX, CRF_PC_HOLD, CRF_FL_NONE, 16'h0000);
        chk("idx inc", idx, 16'h1300);
    endtask
    // Program counter vector, increment, backward branch and load
    task automatic t_pc;
        seq(CRF_OP_NONE, CRF_PC_VECHI, CRF_FL_NONE, 16'h0012);
        seq(CRF_OP_NONE, CRF_PC_VECLO, CRF_FL_NONE, 16'h0034);
        chk("pc vec", pc, 16'h1234);
        seq(CRF_OP_NONE, CRF_PC_INC, CRF_FL_NONE, 16'h0000);
        chk("pc inc", pc, 16'h1235);
        seq(CRF_OP_NONE, CRF_PC_BRANCH, CRF_FL_NONE, 16'h00FE);
        chk("pc back", pc, 16'h1233);
        seq(CRF_OP_NONE, CRF_PC_LOAD, CRF_FL_NONE, 16'hABCD);
        chk("pc load", pc, 16'hABCD);
    endtask
    // Stack pointer arithmetic
    task automatic t_sp;
        seq(CRF_OP_LDSP, CRF_PC_HOLD, CRF_FL_NONE, 16'h1280);
        seq(CRF_OP_AIS, CRF_PC_HOLD, CRF_FL_NONE, 16'h0080);
        chk("sp add neg", sp, 16'h1200);
        seq(CRF_OP_RSP, CRF_PC_HOLD, CRF_FL_NONE, 16'h0000);
        chk("sp low reset", sp, 16'h12FF);
        seq(CRF_OP_PUSH, CRF_PC_HOLD, CRF_FL_NONE, 16'h0000);
        chk("sp push", sp, 16'h12FE);
        seq(CRF_OP_PULL, CRF_PC_HOLD, CRF_FL_NONE, 16'h0000);
        chk("sp pull", sp, 16'h12FF);
    endtask
    // Flag updates, including decimal adjust
    task automatic t_flags;
        seq(CRF_OP_NONE, CRF_PC_HOLD, CRF_FL_WRITE, 16'h0000);
        chk("ccr fixed", ccr, 8'h60);
        seq(CRF_OP_NONE, CRF_PC_HOLD, CRF_FL_ADD, 16'h0, 5'h0, {8'h08, 8'h08, 1'h0, 8'h10});
        chk("ccr half", ccr, 8'h70);
        seq(CRF_OP_NONE, CRF_PC_HOLD, CRF_FL_ADD, 16'h0, 5'h0, {8'h80, 8'h80, 1'h0, 8'h00});
        chk("ccr ovf", ccr, 8'hE3);
        seq(CRF_OP_NONE, CRF_PC_HOLD, CRF_FL_SUB, 16'h0, 5'h0, {8'h00, 8'h01, 1'h0, 8'hFF});
        chk("ccr borrow", ccr, 8'h65);
        seq(CRF_OP_NONE, CRF_PC_HOLD, CRF_FL_NZ8, 16'h0);
        chk("ccr zero", ccr, 8'h63);
        seq(CRF_OP_NONE, CRF_PC_HOLD, CRF_FL_NZ16, 16'h8000);
        chk("ccr neg16", ccr, 8'h65);
        seq(CRF_OP_NONE, CRF_PC_HOLD, CRF_FL_SHIFT, 16'h0);
        chk("ccr shift", ccr, 8'h62);
        seq(CRF_OP_LDA, CRF_PC_HOLD, CRF_FL_ADD, 16'h0, 5'h0, {8'h09, 8'h09, 1'h0, 8'h12});
        seq(CRF_OP_DAA, CRF_PC_HOLD, CRF_FL_NONE, 16'h0000);
        chk("acc bcd", acc, 8'h18);
    endtask
    // Paged window mapping
    task automatic t_page;
        @(posedge clk);
        cpu_addr <= 16'h8123;
        seq(CRF_OP_NONE, CRF_PC_HOLD, CRF_FL_NONE, 16'h0005, 5'h04);
        @(negedge clk);
        chk("page", page, 8'h05);
        chk("phys", phys, {8'h05, 14'h0123});
        // Outside the window the address passes unchanged
        @(posedge clk);
        cpu_addr <= 16'h4321;
        repeat (2) @(negedge clk);
        chk("phys flat", phys, 22'h004321);
    endtask
    // Interrupt hold-off after mask clear, then entry stacking
    task automatic t_irq;
        int n;
        seq(CRF_OP_LDSP, CRF_PC_HOLD, CRF_FL_WRITE, 16'h0200, 5'h10);
        irq_req <= 1'h1;
        // Mask clear, then a boundary on the very next edge
        @(posedge clk);
        clr_i <= 1'h1;
        @(posedge clk);
        clr_i <= 1'h0;
        boundary <= 1'h1;
        @(posedge clk);
        boundary <= 1'h0;
        repeat (3) @(negedge clk);
        chk("irq held off", irq_take, 1'h0);
        chk("no stacking", mem.order_q.size(), 0);
        seq(CRF_OP_NONE, CRF_PC_HOLD, CRF_FL_NONE, 16'h0000, 5'h02);
        n = 0;
        while (mem.order_q.size() < 5 && n < 20) begin
            @(negedge clk);
            n++;
        end
        irq_req <= 1'h0;
        chk("pushes", mem.order_q.size(), 5);
        foreach (mem.order_q[i]) chk("push addr", mem.order_q[i], 16'h0200 - i);
        chk("push pcl", mem.mem[16'h0200], 8'hCD);
        chk("push pch", mem.mem[16'h01FF], 8'hAB);
        chk("push x", mem.mem[16'h01FE], 8'h00);
        chk("push a", mem.mem[16'h01FD], 8'h18);
        chk("push ccr", mem.mem[16'h01FC], 8'h60);
        chk("sp after", sp, 16'h01FB);
        chk("mask set", ccr[3], 1'h1);
    endtask
    // Register access over APB
    task automatic t_apb;
        apb(1'h1, OFF_ACC, 32'h0000_00A5);
        apb(1'h0, OFF_ACC, 32'h0);
        chk("apb acc", rd, 32'h0000_00A5);
        apb(1'h1, OFF_CCR, 32'h0);
        apb(1'h0, OFF_CCR, 32'h0);
        chk("apb ccr", rd, 32'h0000_0060);
        chk("apb ok", err, 1'h0);
        apb(1'h0, 8'h40, 32'h0);
        chk("apb unmapped", err, 1'h1);
    endtask
    ////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #2000000;
        fail_count++;
        finish_test();
    end
    // Main sequence
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'h1, 43'h0};
        op = CRF_OP_NONE;
        pc_op = CRF_PC_HOLD;
        fl_op = CRF_FL_NONE;
        {data, cpu_addr} = 32'h0;
        {alu_a, alu_b, alu_cin, alu_res, shift_c} = 26'h0;
        {set_i, clr_i, irq_req, boundary, page_ld} = 5'h0;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        @(negedge clk);
        t_reset();
        t_pc();
        t_sp();
        t_flags();
        t_page();
        t_irq();
        t_apb();
        finish_test();
    end
endmodule

/* File: sim/crf_stack_mem.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// Stack memory that receives the interrupt stacking writes
module crf_stack_mem (
    // Clock
    input wire logic clk_i,
    // Write port from the register block
    input wire logic we_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] data_i
);
    // Stored bytes, any address of the space
    logic [7:0] mem [logic [15:0]];
    // Addresses in arrival order
    logic [15:0] order_q [$];
    ////////////////////////////////////////////////////////////
    // Capture each write at the clock edge
    always @(posedge clk_i) begin
        if (we_i === 1'h1) begin
            mem[addr_i] = data_i;
            order_q.push_back(addr_i);
        end
    end
endmodule
